// file: hw/charge_and_supply_average_readout.sv
// Charge counter and supply average readout registers over Wishbone
`timescale 1ns/1ps
module charge_and_supply_average_readout
	import readout_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic pulse_i,
	input wire logic standalone_i,
	input wire logic [SAMPLE_WIDTH-1:0] battery_sample_i,
	input wire logic [SAMPLE_WIDTH-1:0] aux_sample_i,
	input wire logic sample_valid_i,
	output logic cal_active_o
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [1:0] pulse_s1_r, pulse_s2_r;
	logic pulse_d_r;
	always_ff @(posedge clk_i) begin
		pulse_s1_r <= {standalone_i, pulse_i};
		pulse_s2_r <= pulse_s1_r;
		pulse_d_r <= pulse_s2_r[0];
	end
	wire logic pulse_edge = pulse_s2_r[0] && !pulse_d_r;
	wire logic standalone = pulse_s2_r[1];

	// ****************************************
	// Bus slave
	// ****************************************
	control_type ctrl_r;
	logic [7:0] charge_low_shadow_r, avg_low_shadow_r;
	logic [15:0] charge_count_r;
	logic [SAMPLE_WIDTH+ACC_FRAC-1:0] acc_r;
	wire logic req = cyc_i && stb_i && !ack_o;
	wire logic rd = req && !we_i;
	wire logic [SAMPLE_WIDTH-1:0] avg_value = acc_r[SAMPLE_WIDTH+ACC_FRAC-1:ACC_FRAC];
	wire logic addr_charge = cyc_i && stb_i &&
		(adr_i == ADDR_CHARGE_HIGH || adr_i == ADDR_CHARGE_LOW);
	wire logic addr_avg = cyc_i && stb_i && (adr_i == ADDR_AVG_HIGH || adr_i == ADDR_AVG_LOW);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (rd) begin
			unique case (adr_i)
				ADDR_CHARGE_HIGH: dat_o <= {24'h0, charge_count_r[15:8]};
				ADDR_CHARGE_LOW: dat_o <= {24'h0, charge_low_shadow_r};
				ADDR_AVG_HIGH: dat_o <= {28'h0, avg_value[11:8]};
				ADDR_AVG_LOW: dat_o <= {24'h0, avg_low_shadow_r};
				ADDR_CONTROL: dat_o <= {24'h0, ctrl_r};
				default: dat_o <= 32'h0;
			endcase
		end
	end
	// Control register; clear and cal bits self-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= control_type'(CONTROL_RESET);
		end else if (req && we_i && sel_i[0] && adr_i == ADDR_CONTROL) begin
			ctrl_r <= control_type'(dat_i[7:0]);
		end else begin
			ctrl_r.clear <= 1'b0;
			ctrl_r.cal <= 1'b0;
		end
	end

	// ****************************************
	// Shadow capture
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			charge_low_shadow_r <= BYTE_RESET;
			avg_low_shadow_r <= BYTE_RESET;
		end else if (rd && adr_i == ADDR_CHARGE_HIGH) begin
			charge_low_shadow_r <= charge_count_r[7:0];
		end else if (rd && adr_i == ADDR_AVG_HIGH) begin
			avg_low_shadow_r <= avg_value[7:0];
		end
	end

	// ****************************************
	// Charge counter and calibration
	// ****************************************
	logic [1:0] pre_r;
	logic [4:0] tick_r;
	logic [15:0] charge_nxt;
	assign cal_active_o = 1'b0;
	wire logic [1:0] pre_lim = ctrl_r.charge_pulse_prescaler;
	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_r.cal) begin
			tick_r <= 5'h0;
		end else if (tick_r == 5'(CAL_TICK_CYCLES - 1)) begin
			tick_r <= 5'h0;
		end else begin
			tick_r <= tick_r + 5'h1;
		end
	end
	// Calibration event is one control write; counter zeroed, then held while flagged
	logic cal_mode_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_r.clear) begin
			cal_mode_r <= 1'b0;
		end else if (ctrl_r.cal) begin
			cal_mode_r <= 1'b1;
		end
	end
	always_comb begin
		charge_nxt = charge_count_r;
		if (ctrl_r.cal) begin
			charge_nxt = 16'h0;
		end else if (cal_mode_r) begin
			charge_nxt = charge_count_r;
		end else if (pulse_edge && standalone && pre_r == pre_lim) begin
			charge_nxt = charge_count_r + 16'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_r.clear || ctrl_r.cal) begin
			pre_r <= 2'h0;
		end else if (pulse_edge && standalone) begin
			pre_r <= (pre_r == pre_lim) ? 2'h0 : pre_r + 2'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_r.clear) begin
			charge_count_r <= 16'h0;
		end else if (!addr_charge) begin
			charge_count_r <= charge_nxt;
		end
	end

	// ****************************************
	// Supply average filter
	// ****************************************
	wire logic [SAMPLE_WIDTH-1:0] sample =
		ctrl_r.aux_supply_present_mode ? aux_sample_i : battery_sample_i;
	wire logic [SAMPLE_WIDTH+ACC_FRAC-1:0] sample_ext = {sample, 8'h0};
	wire logic [3:0] tau = 4'(ctrl_r.average_filter_time_constant) + 4'(TAU_SHIFT_BASE);
	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_r.clear) begin
			acc_r <= '0;
		end else if (sample_valid_i && !addr_avg) begin
			acc_r <= acc_r - (acc_r >> tau) + (sample_ext >> tau);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> ack_o) else $error("ack missing");
	ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held");
	charge_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		addr_charge && !ctrl_r.clear |=> $stable(charge_count_r)) else $error("update");
	avg_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		addr_avg && !ctrl_r.clear |=> $stable(acc_r)) else $error("avg update");
	shadow_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && adr_i == ADDR_CHARGE_HIGH |=> charge_low_shadow_r == $past(charge_count_r[7:0]))
		else $error("shadow");
	low_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && adr_i == ADDR_CHARGE_LOW |=> dat_o[7:0] == $past(charge_low_shadow_r))
		else $error("low read");
	avg_shadow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && adr_i == ADDR_AVG_HIGH |=> avg_low_shadow_r == $past(avg_value[7:0]))
		else $error("avg shadow");
	nibble_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && adr_i == ADDR_AVG_HIGH |=> dat_o[31:4] == 28'h0) else $error("nibble");
	cal_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cal_mode_r && !ctrl_r.clear && !ctrl_r.cal |=> $stable(charge_count_r))
		else $error("cal count");
	clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_r.clear |=> charge_count_r == 16'h0 && acc_r == '0) else $error("clear");
	count_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
		charge_count_r != $past(charge_count_r));
	pair_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
		rd && adr_i == ADDR_CHARGE_HIGH ##[2:10] rd && adr_i == ADDR_CHARGE_LOW);
	cal_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(cal_mode_r));
endmodule : charge_and_supply_average_readout

// file: hw/readout_pkg.sv
// Constants and types for the charge and supply average readout block
// Function
// - Low byte of third-output charge counter, read-only at 0x1A, resets to zero.
// - Each count step equals a prescaler-selected group of regulator pulses.
// - During calibration the third-output counter counts 10MHz clock cycles; the code zeroes it and holds it instead.
// - After calibration, until next clear, both bytes read the 16-bit cycle count; the code holds the counter at zero, so both read zero.
// - Addressing a readout register suspends updates to that register.
// - High-part read copies the live low byte into a shadow register.
// - Low-byte read returns the shadow copied by the preceding high-part read.
// - 12-bit average: high nibble bits 3:0 at 0x1B, low byte at 0x1C.
// - Average is an IIR low-pass filter with selectable time constant.
// - Auxiliary pin measured when supply-mode bit is 1, else battery pin.
package readout_pkg;
	localparam logic [7:0] ADDR_CHARGE_HIGH = 8'h19;
	localparam logic [7:0] ADDR_CHARGE_LOW = 8'h1a;
	localparam logic [7:0] ADDR_AVG_HIGH = 8'h1b;
	localparam logic [7:0] ADDR_AVG_LOW = 8'h1c;
	localparam logic [7:0] ADDR_CONTROL = 8'h20;
	localparam int CTRL_PRESCALE_LSB = 0;
	localparam int CTRL_TAU_LSB = 2;
	localparam int CTRL_AUX_BIT = 5;
	localparam int CTRL_CLEAR_BIT = 6;
	localparam int CTRL_CAL_BIT = 7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int SAMPLE_WIDTH = 12;
	localparam int CLOCK_MHZ = 200;
	localparam int CAL_CLOCK_MHZ = 10;
	localparam int CAL_TICK_CYCLES = CLOCK_MHZ / CAL_CLOCK_MHZ;
	localparam int TAU_SHIFT_BASE = 2;
	localparam int ACC_FRAC = 8;

	typedef struct packed {
		logic cal;
		logic clear;
		logic aux_supply_present_mode;
		logic [2:0] average_filter_time_constant;
		logic [1:0] charge_pulse_prescaler;
	} control_type;
endpackage : readout_pkg

// file: tb/charge_and_supply_average_readout_bench.sv
// Self-checking bench for the charge and supply average readout block
`timescale 1ns/1ps
module charge_and_supply_average_readout_bench;
	import readout_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pulse_i, standalone_i, sample_valid_i;
	logic cal_active_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic [SAMPLE_WIDTH-1:0] battery_sample_i, aux_sample_i;
	logic [19:0] acc;
	logic [7:0] lo;
	int miscompares, checked;

	charge_and_supply_average_readout dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .pulse_i(pulse_i), .standalone_i(standalone_i),
		.battery_sample_i(battery_sample_i), .aux_sample_i(aux_sample_i),
		.sample_valid_i(sample_valid_i), .cal_active_o(cal_active_o));

	// ****************
	// Bus and stimulus tasks
	// ****************
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t read %h expected %h", $time, g, e);
		end
	endtask : ck

	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) ck(8'h00, 8'hff);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(a, 1'b0, 8'h00, q);
		ck(q, e);
	endtask : rd

	task automatic pulses(input int n);
		repeat (n) begin
			pulse_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			pulse_i <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask : pulses

	task automatic samples(input int n, input logic [11:0] s, input int sh);
		repeat (n) begin
			sample_valid_i <= 1'b1;
			@(posedge clk_i);
			sample_valid_i <= 1'b0;
			@(posedge clk_i);
			acc = acc - (acc >> sh) + ({s, 8'h00} >> sh);
		end
		repeat (2) @(posedge clk_i);
	endtask : samples

	task automatic test_done;
		if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// ****************
	// Clock, watchdog
	// ****************
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		#100us;
		miscompares++;
		test_done();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		{cyc_i, stb_i, we_i, pulse_i, sample_valid_i} = 5'h00;
		adr_i = 8'h00;
		dat_i = 32'h00000000;
		sel_i = 4'h1;
		standalone_i = 1'b1;
		battery_sample_i = 12'habc;
		aux_sample_i = 12'h5e3;
		miscompares = 0;
		checked = 0;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		rd(ADDR_CHARGE_LOW, 8'h00);
		rd(ADDR_AVG_HIGH, 8'h00);
		rd(ADDR_AVG_LOW, 8'h00);
		rd(8'h30, 8'h00);
		pulses(5);
		wr(ADDR_CHARGE_LOW, 8'h77);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		rd(ADDR_CHARGE_LOW, 8'h05);
		wr(ADDR_CONTROL, 8'h41);
		pulses(6);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		pulses(2);
		rd(ADDR_CHARGE_LOW, 8'h03);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		rd(ADDR_CHARGE_LOW, 8'h04);
		wr(ADDR_CONTROL, 8'h80);
		pulses(4);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		rd(ADDR_CHARGE_LOW, 8'h00);
		ck({7'h00, cal_active_o}, 8'h00);
		wr(ADDR_CONTROL, 8'h40);
		pulses(3);
		rd(ADDR_CHARGE_HIGH, 8'h00);
		rd(ADDR_CHARGE_LOW, 8'h03);
		acc = 20'h00000;
		samples(30, battery_sample_i, TAU_SHIFT_BASE);
		rd(ADDR_AVG_HIGH, {4'h0, acc[19:16]});
		lo = acc[15:8];
		samples(3, battery_sample_i, TAU_SHIFT_BASE);
		rd(ADDR_AVG_LOW, lo);
		wr(ADDR_AVG_HIGH, 8'h00);
		rd(ADDR_AVG_HIGH, {4'h0, acc[19:16]});
		wr(ADDR_CONTROL, 8'h64);
		acc = 20'h00000;
		samples(40, aux_sample_i, TAU_SHIFT_BASE + 1);
		rd(ADDR_AVG_HIGH, {4'h0, acc[19:16]});
		rd(ADDR_AVG_LOW, acc[15:8]);
		test_done();
	end
endmodule : charge_and_supply_average_readout_bench
